// file: acc_pkg.sv
// Constants, states and carriers shared by the command and calibration engine.
// Assumes one 40 MHz master clock and a host-driven serial clock on the link.
// Functional notes
// - Gain word is unsigned 24-bit; code 400000h multiplies by exactly one.
// - Gain word resets to 400000h so no gain correction applies.
// - Gain scales linearly: 800000h doubles, 200000h halves, zero gives zero.
// - Each 24-bit word spans three byte registers, low address holds bits 7..0.
// - Stop, synchronize, start; ready strobe follows 64 data periods later.
// - After ready: stop, calibrate, start; result valid after 16 data periods.
// - Sinc-only filter mode passes filter output without offset or gain.
// - Offset calibration averages 16 readings into the offset word.
// - Offset calibration averages readings without gain applied.
// - Gain calibration averages 16 readings, stores gain mapping input to full scale.
// - Calibrated words remain readable and writable through register commands.
// - Commands accepted only in register mode; pin mode leaves decoder idle.
// - Opcodes are one byte; register read and write add a count byte and data.
// - Continuous mode shifts conversion data out on serial clock without opcode.
// - Stop-continuous disables automatic output; data then leaves only on read opcodes.
// - Wake, standby, sync, reset opcodes ignore their least significant bit.
// - 10h starts continuous, 11h stops continuous, 12h reads data by command.
// - Read header 20h plus address, write header 40h plus address, then count byte.
// - 60h is offset calibration, 61h is gain calibration.
// - Count field equals number of registers to transfer minus one.
// - Output equals filter output minus offset, times gain over 400000h.
// - Offset word is twos complement, left-justified against the 32-bit result.
package acc_pkg;
	localparam logic [7:0]  OP_WAKEUP    = 8'h00;
	localparam logic [7:0]  OP_STANDBY   = 8'h02;
	localparam logic [7:0]  OP_SYNC      = 8'h04;
	localparam logic [7:0]  OP_RESET     = 8'h06;
	localparam logic [7:0]  OP_START     = 8'h10;
	localparam logic [7:0]  OP_STOP      = 8'h11;
	localparam logic [7:0]  OP_RDATA     = 8'h12;
	localparam logic [7:0]  OP_REG_RD    = 8'h20;
	localparam logic [7:0]  OP_REG_WR    = 8'h40;
	localparam logic [7:0]  OP_OFFCAL    = 8'h60;
	localparam logic [7:0]  OP_GAINCAL   = 8'h61;
	localparam logic [4:0]  ADDR_OFF_LO  = 5'h05;
	localparam logic [4:0]  ADDR_GAIN_LO = 5'h08;
	localparam logic [23:0] OFFSET_RESET = 24'h00_0000;
	localparam logic [23:0] GAIN_RESET   = 24'h40_0000;
	localparam logic [23:0] GAIN_MAX     = 24'hFF_FFFF;
	localparam logic [31:0] POS_FULL     = 32'h7FFF_FFFF;
	localparam logic [31:0] NEG_FULL     = 32'h8000_0000;
	localparam logic [32:0] DIV_SEED     = 33'h0_1000_0000;
	localparam int          GAIN_FRAC    = 22;
	localparam int          CAL_READINGS = 16;
	localparam int          SETTLE_READS = 64;
	localparam int          DIV_STEPS    = 25;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00001,
		ST_RD_CNT  = 5'b00010,
		ST_WR_CNT  = 5'b00100,
		ST_RD_DATA = 5'b01000,
		ST_WR_DATA = 5'b10000
	} acc_cmd_state_t;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_SUM  = 3'b010,
		CAL_DIV  = 3'b100
	} acc_cal_state_t;

	typedef struct packed {
		logic [31:0] data;
		logic        valid;
	} acc_sample_t;
endpackage : acc_pkg

// file: acc_command_cal.sv
// Serial command decoder, offset/gain correction and calibration engine.
// Assumes filter samples arrive on clk; sclk, din, pin_mode and sync_pin come from pins.
`timescale 1ns/1ps
module acc_command_cal
	import acc_pkg::*;
(
	input  logic        clk,
	input  logic        reset_n,
	input  logic        sclk,
	input  logic        din,
	input  logic        pin_mode,
	input  logic        sync_pin,
	input  logic        sinc_mode,
	input  acc_sample_t filt,
	output logic        dout,
	output logic        ready_strobe_n,
	output acc_sample_t result,
	output logic        continuous_mode,
	output logic        standby,
	output logic        conv_restart
);
	logic [7:0]     rx_sh;
	logic [2:0]     rx_bits;
	logic [7:0]     rx_byte;
	logic           rx_tgl;
	logic           rx_t1, rx_t2, rx_t3;
	logic           sk1, sk2, sk3;
	logic           pin1, pin_s, sy1, sync_s;
	logic           byte_evt, sclk_fall, cmd_evt;
	logic [7:0]     op;
	logic           op_wake, op_standby, op_sync, soft_rst, op_start, op_stop;
	logic           op_rdata, op_reg_rd, op_reg_wr, op_offcal, op_gaincal, op_known;
	acc_cmd_state_t cmd_st;
	logic [4:0]     addr;
	logic [4:0]     cnt;
	logic           wr_evt, rd_load;
	logic [4:0]     rd_sel;
	logic [7:0]     rd_val;
	logic [7:0]     rd_byte;
	logic           rd_pend;
	logic [31:0]    tx_sh;
	logic [23:0]    offset_word;
	logic [23:0]    gain_word;
	logic           rdata_pend;
	logic [6:0]     settle;
	logic signed [32:0] diff;
	logic signed [57:0] prod;
	logic signed [35:0] scaled;
	logic [31:0]    corr;
	logic           deliverable, deliver;
	acc_cal_state_t cal_st;
	logic           cal_gain;
	logic [3:0]     cal_cnt;
	logic [36:0]    cal_acc, next_sum;
	logic [32:0]    cal_term, avg;
	logic           cal_take, cal_last, gbad;
	logic           off_cal_done, gain_cal_done;
	logic [23:0]    gain_cal_val;
	logic [31:0]    div_d;
	logic [32:0]    div_rem, rem2;
	logic [24:0]    div_q;
	logic [4:0]     div_n;
	logic           ge;

	// Link side: the host launches din around sclk, so sclk samples it directly
	always_ff @(posedge sclk) begin
		if (!reset_n) begin
			rx_sh   <= 8'h00;
			rx_bits <= 3'h0;
			rx_byte <= 8'h00;
			rx_tgl  <= 1'b0;
		end else begin
			rx_sh   <= {rx_sh[6:0], din};
			rx_bits <= rx_bits + 3'h1;
			if (rx_bits == 3'h7) begin
				rx_byte <= {rx_sh[6:0], din};
				rx_tgl  <= ~rx_tgl;
			end
		end
	end

	// Two-flop synchronisers; rx_byte is quasi-static once its toggle is seen
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_t1  <= 1'b0;
			rx_t2  <= 1'b0;
			rx_t3  <= 1'b0;
			sk1    <= 1'b0;
			sk2    <= 1'b0;
			sk3    <= 1'b0;
			pin1   <= 1'b0;
			pin_s  <= 1'b0;
			sy1    <= 1'b1;
			sync_s <= 1'b1;
		end else begin
			rx_t1  <= rx_tgl;
			rx_t2  <= rx_t1;
			rx_t3  <= rx_t2;
			sk1    <= sclk;
			sk2    <= sk1;
			sk3    <= sk2;
			pin1   <= pin_mode;
			pin_s  <= pin1;
			sy1    <= sync_pin;
			sync_s <= sy1;
		end
	end

	// Byte arrival relies on the host gap of 26 clocks to keep rx_byte steady
	assign byte_evt  = rx_t2 ^ rx_t3;
	assign sclk_fall = sk3 & ~sk2;
	assign op        = rx_byte;
	assign cmd_evt   = byte_evt && (cmd_st == ST_IDLE) && !pin_s;

	// First-byte decode
	assign op_wake    = cmd_evt && (op[7:1] == OP_WAKEUP[7:1]);
	assign op_standby = cmd_evt && (op[7:1] == OP_STANDBY[7:1]);
	assign op_sync    = cmd_evt && (op[7:1] == OP_SYNC[7:1]);
	assign soft_rst   = cmd_evt && (op[7:1] == OP_RESET[7:1]);
	assign op_start   = cmd_evt && (op == OP_START);
	assign op_stop    = cmd_evt && (op == OP_STOP);
	assign op_rdata   = cmd_evt && (op == OP_RDATA);
	assign op_reg_rd  = cmd_evt && (op[7:5] == OP_REG_RD[7:5]);
	assign op_reg_wr  = cmd_evt && (op[7:5] == OP_REG_WR[7:5]);
	assign op_offcal  = cmd_evt && (op == OP_OFFCAL);
	assign op_gaincal = cmd_evt && (op == OP_GAINCAL);
	assign op_known   = op_wake | op_standby | op_sync | soft_rst | op_start | op_stop
		| op_rdata | op_reg_rd | op_reg_wr | op_offcal | op_gaincal;

	// Header, count and data sequencing; unknown bytes leave everything alone
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cmd_st <= ST_IDLE;
			addr   <= 5'h00;
			cnt    <= 5'h00;
		end else begin
			unique case (cmd_st)
				ST_IDLE: begin
					if (op_reg_rd || op_reg_wr) begin
						addr   <= op[4:0];
						cmd_st <= op_reg_rd ? ST_RD_CNT : ST_WR_CNT;
					end
				end
				ST_RD_CNT, ST_WR_CNT: begin
					if (byte_evt) begin
						cnt    <= rx_byte[4:0];
						cmd_st <= (cmd_st == ST_RD_CNT) ? ST_RD_DATA : ST_WR_DATA;
					end
				end
				ST_RD_DATA, ST_WR_DATA: begin
					if (byte_evt) begin
						if (cnt == 5'h00) begin
							cmd_st <= ST_IDLE;
						end else begin
							cnt  <= cnt - 5'h01;
							addr <= addr + 5'h01;
						end
					end
				end
				default: cmd_st <= ST_IDLE;
			endcase
		end
	end

	assign wr_evt  = byte_evt && (cmd_st == ST_WR_DATA);
	assign rd_load = byte_evt && ((cmd_st == ST_RD_CNT) || (cmd_st == ST_RD_DATA && cnt != 5'h00));
	assign rd_sel  = (cmd_st == ST_RD_CNT) ? addr : addr + 5'h01;

	// Register read mux; addresses outside the calibration bytes read zero
	always_comb begin
		rd_val = 8'h00;
		for (int i = 0; i < 3; i++) begin
			if (rd_sel == ADDR_OFF_LO + 5'(i)) rd_val = offset_word[8*i +: 8];
			if (rd_sel == ADDR_GAIN_LO + 5'(i)) rd_val = gain_word[8*i +: 8];
		end
	end

	// Calibration byte registers; an engine result wins over a host write
	for (genvar i = 0; i < 3; i++) begin : g_cal_bytes
		logic [7:0] ob;
		logic [7:0] gb;
		always_ff @(posedge clk) begin
			if (!reset_n || soft_rst) begin
				ob <= OFFSET_RESET[8*i +: 8];
				gb <= GAIN_RESET[8*i +: 8];
			end else begin
				if (off_cal_done) begin
					ob <= next_sum[12+8*i +: 8];
				end else if (wr_evt && addr == ADDR_OFF_LO + 5'(i)) begin
					ob <= rx_byte;
				end
				if (gain_cal_done) begin
					gb <= gain_cal_val[8*i +: 8];
				end else if (wr_evt && addr == ADDR_GAIN_LO + 5'(i)) begin
					gb <= rx_byte;
				end
			end
		end
		assign offset_word[8*i +: 8] = ob;
		assign gain_word[8*i +: 8]   = gb;
	end

	// Mode flags
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			continuous_mode <= 1'b1;
			standby         <= 1'b0;
			rdata_pend      <= 1'b0;
		end else begin
			if (op_start) continuous_mode <= 1'b1;
			if (op_stop) continuous_mode <= 1'b0;
			if (op_standby) standby <= 1'b1;
			if (op_wake) standby <= 1'b0;
			if (op_rdata) rdata_pend <= 1'b1;
			else if (deliver) rdata_pend <= 1'b0;
		end
	end

	// Restart pulse toward the conversion chain
	always_ff @(posedge clk) begin
		if (!reset_n) conv_restart <= 1'b0;
		else conv_restart <= op_sync || soft_rst;
	end

	// Settling: skip 63 readings after a restart, so the 64th is the first shown
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			settle <= 7'h00;
		end else if (op_sync || soft_rst || !sync_s) begin
			settle <= 7'(SETTLE_READS - 1);
		end else if (filt.valid && settle != 7'h00) begin
			settle <= settle - 7'h01;
		end
	end

	// Correction: full-width multiply, then saturate to 32 bits
	always_comb begin
		diff   = $signed({filt.data[31], filt.data}) - $signed({offset_word[23], offset_word, 8'h00});
		prod   = diff * $signed({1'b0, gain_word});
		scaled = prod[57:GAIN_FRAC];
		if (sinc_mode) corr = filt.data;
		else if (scaled[35:31] != {5{scaled[31]}}) corr = scaled[35] ? NEG_FULL : POS_FULL;
		else corr = scaled[31:0];
	end

	// Readings taken by the calibration engine are never shown
	// A reading that meets a sync or reset opcode is cancelled with the conversion in progress
	assign deliverable = filt.valid && settle == 7'h00 && cal_st == CAL_IDLE
		&& !op_sync && !soft_rst;
	assign deliver     = deliverable && (continuous_mode || rdata_pend);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			result <= '0;
		end else begin
			result.valid <= deliverable;
			if (deliverable) result.data <= corr;
		end
	end

	// Output shifter: sample words load at once, register bytes at the next sclk fall
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_sh          <= 32'h0000_0000;
			dout           <= 1'b0;
			ready_strobe_n <= 1'b1;
			rd_byte        <= 8'h00;
			rd_pend        <= 1'b0;
		end else begin
			if (rd_load) begin
				rd_byte <= rd_val;
				rd_pend <= 1'b1;
			end else if (sclk_fall) begin
				rd_pend <= 1'b0;
			end
			if (deliver) begin
				dout           <= corr[31];
				tx_sh          <= {corr[30:0], 1'b0};
				ready_strobe_n <= 1'b0;
			end else if (sclk_fall) begin
				ready_strobe_n <= 1'b1;
				if (rd_pend) begin
					dout  <= rd_byte[7];
					tx_sh <= {rd_byte[6:0], 25'h000_0000};
				end else begin
					dout  <= tx_sh[31];
					tx_sh <= {tx_sh[30:0], 1'b0};
				end
			end
		end
	end

	// Calibration sums raw input for offset and offset-corrected input for gain
	assign cal_term     = cal_gain ? diff : {filt.data[31], filt.data};
	assign next_sum     = cal_acc + {{4{cal_term[32]}}, cal_term};
	assign avg          = next_sum[36:4];
	assign gbad         = avg[32] || (avg[31:29] == 3'b000);
	assign cal_take     = (cal_st == CAL_SUM) && filt.valid && sync_s;
	assign cal_last     = cal_take && (cal_cnt == 4'(CAL_READINGS - 1));
	assign off_cal_done = cal_last && !cal_gain;
	assign rem2         = {div_rem[31:0], 1'b0};
	assign ge           = rem2 >= {1'b0, div_d};
	assign gain_cal_done = (cal_last && cal_gain && gbad)
		|| (cal_st == CAL_DIV && div_n == 5'(DIV_STEPS));
	// Quotients past 24 bits, or a non-positive average, clamp to the largest gain
	assign gain_cal_val = (cal_st == CAL_DIV && !div_q[24]) ? div_q[23:0] : GAIN_MAX;

	// Engine: sum 16 readings, then divide 2^53 by the average for the gain word
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			cal_st   <= CAL_IDLE;
			cal_gain <= 1'b0;
			cal_cnt  <= 4'h0;
			cal_acc  <= '0;
			div_d    <= 32'h0000_0000;
			div_rem  <= '0;
			div_q    <= '0;
			div_n    <= 5'h00;
		end else begin
			unique case (cal_st)
				CAL_IDLE: begin
					if (op_offcal || op_gaincal) begin
						cal_st   <= CAL_SUM;
						cal_gain <= op_gaincal;
						cal_cnt  <= 4'h0;
						cal_acc  <= '0;
					end
				end
				CAL_SUM: begin
					if (cal_take) begin
						cal_acc <= next_sum;
						cal_cnt <= cal_cnt + 4'h1;
						if (cal_last) begin
							if (!cal_gain || gbad) begin
								cal_st <= CAL_IDLE;
							end else begin
								cal_st  <= CAL_DIV;
								div_d   <= avg[31:0];
								div_rem <= DIV_SEED;
								div_q   <= '0;
								div_n   <= 5'h00;
							end
						end
					end
				end
				CAL_DIV: begin
					if (div_n == 5'(DIV_STEPS)) begin
						cal_st <= CAL_IDLE;
					end else begin
						div_rem <= ge ? rem2 - {1'b0, div_d} : rem2;
						div_q   <= {div_q[23:0], ge};
						div_n   <= div_n + 5'h01;
					end
				end
				default: cal_st <= CAL_IDLE;
			endcase
		end
	end

	property p_gain_reset;
		@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> gain_word == GAIN_RESET;
	endproperty
	a_gain_reset: assert property (p_gain_reset) else $error("gain word not at unity");

	property p_unity;
		@(posedge clk) disable iff (!reset_n)
		(deliverable && !sinc_mode && offset_word == 24'h00_0000 && gain_word == GAIN_RESET)
		|=> result.data == $past(filt.data);
	endproperty
	a_unity: assert property (p_unity) else $error("unity gain altered data");

	property p_half;
		@(posedge clk) disable iff (!reset_n)
		(deliverable && !sinc_mode && offset_word == 24'h00_0000 && gain_word == 24'h20_0000)
		|=> result.data == {$past(filt.data[31]), $past(filt.data[31:1])};
	endproperty
	a_half: assert property (p_half) else $error("half gain wrong");

	property p_sinc;
		@(posedge clk) disable iff (!reset_n)
		(deliverable && sinc_mode) |=> result.data == $past(filt.data);
	endproperty
	a_sinc: assert property (p_sinc) else $error("sinc mode not bypassed");

	property p_off_cal;
		@(posedge clk) disable iff (!reset_n)
		off_cal_done |=> offset_word == $past(next_sum[35:12]) && cal_st == CAL_IDLE;
	endproperty
	a_off_cal: assert property (p_off_cal) else $error("offset average not stored");

	property p_div_len;
		@(posedge clk) disable iff (!reset_n)
		$rose(cal_st == CAL_DIV) |-> (cal_st == CAL_DIV) [*8] ##[17:19] cal_st == CAL_IDLE;
	endproperty
	a_div_len: assert property (p_div_len) else $error("gain division length wrong");

	property p_pin_idle;
		@(posedge clk) disable iff (!reset_n)
		(pin_s && cmd_st == ST_IDLE) |=> cmd_st == ST_IDLE && $stable(continuous_mode);
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("decoder active in pin mode");

	property p_stop;
		@(posedge clk) disable iff (!reset_n)
		(cmd_evt && op == OP_STOP) |=> !continuous_mode ##1 !continuous_mode;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not end continuous");

	property p_lsb;
		@(posedge clk) disable iff (!reset_n)
		(cmd_evt && op[7:1] == OP_STANDBY[7:1] && op[0]) |=> standby;
	endproperty
	a_lsb: assert property (p_lsb) else $error("standby odd code missed");

	property p_unknown;
		@(posedge clk) disable iff (!reset_n)
		(cmd_evt && !op_known && cal_st == CAL_IDLE) |=> cmd_st == ST_IDLE
		&& $stable(offset_word) && $stable(gain_word) && $stable(continuous_mode);
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown opcode changed state");

	property p_settle;
		@(posedge clk) disable iff (!reset_n)
		op_sync |=> !result.valid [*2];
	endproperty
	a_settle: assert property (p_settle) else $error("data shown while settling");
endmodule : acc_command_cal

// file: acc_host.sv
// Host controller model for the serial command port.
// Assumes din is sampled on sclk rise and dout moves after sclk falls.
`timescale 1ns/1ps
module acc_host (
	output logic sclk,
	output logic din,
	input  logic dout
);
	logic [7:0] rb [0:7];
	logic [7:0] wb [0:7];

	// Link clock stands low between bytes; it never runs free
	initial begin
		sclk = 1'b0;
		din  = 1'b0;
	end

	// One link clock pulse while reset is low; the link-side counters reset on it
	task automatic flush();
		#20 sclk = 1'b1;
		#40 sclk = 1'b0;
	endtask : flush

	// One byte each way; dout is taken late in the high phase for sync slack
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			din = b[i];
			#80 sclk = 1'b1;
			#80 r[i] = dout;
			sclk = 1'b0;
		end
		din = ~b[0]; // Stale level is not left on the line
		#650;
	endtask : xfer

	// Register read: header, count byte, then one dummy byte per register
	task automatic reg_read(input logic [4:0] a, input int n);
		logic [7:0] r;
		xfer({3'b001, a}, r);
		xfer(8'(n - 1), r);
		for (int i = 0; i < n; i++) xfer(8'h00, rb[i]);
	endtask : reg_read

	// Register write: header, count byte, then the data bytes
	task automatic reg_write(input logic [4:0] a, input int n);
		logic [7:0] r;
		xfer({3'b010, a}, r);
		xfer(8'(n - 1), r);
		for (int i = 0; i < n; i++) xfer(wb[i], r);
	endtask : reg_write
endmodule : acc_host

// file: tb_acc_command_cal.sv
// Self-checking bench for the command decoder and calibration engine.
// Assumes acc_pkg is compiled first and acc_host drives the serial port.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_acc_command_cal
	import acc_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        sclk;
	logic        din;
	logic        pin_mode = 1'b0;
	logic        sync_pin = 1'b1;
	logic        sinc_mode = 1'b0;
	acc_sample_t filt = '0;
	logic        dout;
	logic        ready_strobe_n;
	acc_sample_t result;
	logic        continuous_mode;
	logic        standby;
	logic        conv_restart;
	logic [23:0] off_w = 24'h00_0000;
	logic [23:0] gain_w = 24'h40_0000;
	logic [31:0] word;
	logic [7:0]  rx;
	logic        shown;
	int          failures = 0;
	int          n_compared = 0;
	int          n_restart = 0;
	int          k;
	int          r0;
	logic [7:0]  ctl [0:3] = '{8'h02, 8'h01, 8'h03, 8'h00};
	logic [7:0]  bad [0:4] = '{8'h08, 8'h13, 8'h62, 8'h80, 8'hFF};
	logic [23:0] otab [0:3] = '{24'h00_1234, 24'hFF_FFFF, 24'h80_0000, 24'h00_0000};
	logic [23:0] gtab [0:3] = '{24'h80_0000, 24'h00_0000, 24'h80_0000, 24'h20_0000};

	// Master clock, 25 ns
	always #12.5 clk = ~clk;

	// Restart pulses last one cycle, so they are counted as they pass
	always @(posedge clk) if (conv_restart === 1'b1) n_restart <= n_restart + 1;

	acc_command_cal acc_command_cal_inst (
		.clk            (clk),
		.reset_n        (reset_n),
		.sclk           (sclk),
		.din            (din),
		.pin_mode       (pin_mode),
		.sync_pin       (sync_pin),
		.sinc_mode      (sinc_mode),
		.filt           (filt),
		.dout           (dout),
		.ready_strobe_n (ready_strobe_n),
		.result         (result),
		.continuous_mode(continuous_mode),
		.standby        (standby),
		.conv_restart   (conv_restart)
	);

	acc_host host_inst (
		.sclk(sclk),
		.din (din),
		.dout(dout)
	);

	// Corrected output with saturation, from the current words
	function automatic logic [31:0] model(logic [31:0] d);
		longint v;
		v = longint'($signed(d)) - longint'($signed({off_w, 8'h00}));
		v = (v * longint'(gain_w)) >>> 22;
		if (v > 64'sh7FFF_FFFF) v = 64'sh7FFF_FFFF;
		if (v < -64'sh8000_0000) v = -64'sh8000_0000;
		return 32'(v);
	endfunction : model

	task automatic wrap_up();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up

	// One reading; result is looked at in the single cycle it stands
	task automatic push(input logic [31:0] d);
		@(negedge clk);
		filt = '{data: d, valid: 1'b1};
		@(negedge clk);
		filt.valid = 1'b0;
		shown = result.valid;
		word = result.data;
	endtask : push

	// Feed readings until one is shown; k ends as the number fed
	task automatic show(input logic [31:0] d);
		k = 0;
		do begin
			push(d);
			k++;
		end while (shown !== 1'b1 && k < 80);
		if (shown !== 1'b1) begin
			failures++;
			wrap_up();
		end
	endtask : show

	task automatic cmd(input logic [7:0] b);
		host_inst.xfer(b, rx);
	endtask : cmd

	task automatic rd32();
		for (int i = 0; i < 4; i++) begin
			host_inst.xfer(8'h00, rx);
			word = {word[23:0], rx};
		end
	endtask : rd32

	// Reads 05h..0Bh; the last address is unmapped and must read zero
	task automatic chk_regs();
		host_inst.reg_read(5'h05, 7);
		`CHK({host_inst.rb[2], host_inst.rb[1], host_inst.rb[0]}, off_w)
		`CHK({host_inst.rb[5], host_inst.rb[4], host_inst.rb[3]}, gain_w)
		`CHK(host_inst.rb[6], 8'h00)
	endtask : chk_regs

	task automatic set_words(input logic [23:0] o, input logic [23:0] g);
		off_w = o;
		gain_w = g;
		{host_inst.wb[2], host_inst.wb[1], host_inst.wb[0]} = o;
		{host_inst.wb[5], host_inst.wb[4], host_inst.wb[3]} = g;
		host_inst.reg_write(5'h05, 6);
	endtask : set_words

	// Main sequence
	initial begin
		host_inst.flush(); // Link-side counters clear only on a link clock edge
		@(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		`CHK(continuous_mode, 1'b1)
		cmd(OP_STOP);
		`CHK(continuous_mode, 1'b0)
		chk_regs();
		foreach (gtab[i]) begin
			set_words(otab[i], gtab[i]);
			chk_regs();
			show(32'h1000_0000);
			`CHK(word, model(32'h1000_0000))
			`CHK(ready_strobe_n, 1'b1)
		end
		sinc_mode = 1'b1;
		show(32'hC000_0001);
		`CHK(word, 32'hC000_0001)
		sinc_mode = 1'b0;
		cmd(OP_RDATA);
		push(32'h2345_6789);
		`CHK(ready_strobe_n, 1'b0)
		rd32();
		`CHK(word, model(32'h2345_6789))
		foreach (bad[i]) cmd(bad[i]);
		chk_regs();
		`CHK(continuous_mode, 1'b0)
		`CHK(standby, 1'b0)
		@(negedge clk) pin_mode = 1'b1;
		repeat (4) @(negedge clk);
		cmd(OP_START);
		`CHK(continuous_mode, 1'b0)
		@(negedge clk) pin_mode = 1'b0;
		repeat (4) @(negedge clk);
		foreach (ctl[i]) begin
			cmd(ctl[i]);
			`CHK(standby, ctl[i][1])
		end
		r0 = n_restart;
		cmd(8'h04);
		cmd(8'h05);
		`CHK(n_restart, r0 + 2)
		cmd(8'h07);
		`CHK(n_restart, r0 + 3)
		`CHK(continuous_mode, 1'b1)
		off_w = 24'h00_0000;
		gain_w = 24'h40_0000;
		// Ten readings into the settle count, then a low sync level must start it over
		repeat (10) push(32'h0000_0000);
		sync_pin = 1'b0;
		repeat (4) @(negedge clk);
		sync_pin = 1'b1;
		repeat (3) @(negedge clk);
		show(32'h1357_9BDF);
		`CHK(k, 64)
		`CHK(ready_strobe_n, 1'b0)
		rd32();
		`CHK(word, 32'h1357_9BDF)
		`CHK(ready_strobe_n, 1'b1)
		cmd(OP_STOP);
		chk_regs();
		// Gain of two is loaded so that a gained average would show
		set_words(24'h00_0000, 24'h80_0000);
		cmd(OP_OFFCAL);
		for (int i = 0; i < 16; i++) begin
			push(i[0] ? 32'h0012_3500 : 32'h0012_3300);
			`CHK(shown, 1'b0)
		end
		cmd(OP_START);
		cmd(OP_STOP);
		off_w = 24'h00_1234;
		chk_regs();
		set_words(24'h00_0000, 24'h40_0000);
		cmd(OP_GAINCAL);
		repeat (16) push(32'h4000_0000);
		cmd(OP_START);
		cmd(OP_STOP);
		gain_w = 24'h80_0000;
		chk_regs();
		show(32'h2000_0000);
		`CHK(word, 32'h4000_0000)
		wrap_up();
	end
endmodule : tb_acc_command_cal
